// ---- logic/sdf_pkg.sv ----
package sdf_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned ACC_W = 27;
  localparam int unsigned DIV_W = 21;
  localparam logic [31:0] ADDR_FILTER_CTRL = 32'hffff0518;
  localparam logic [31:0] ADDR_EXT_CFG = 32'hffff051c;
  localparam logic [31:0] ADDR_STATUS = 32'hffff0520;
  localparam logic [15:0] FILTER_CTRL_RESET = 16'h0007;
  localparam logic [7:0] EXT_CFG_RESET = 8'h00;
  localparam int unsigned CHOP_BIT = 15;
  localparam int unsigned RUNAVG_BIT = 14;
  localparam int unsigned AVG_HI = 13;
  localparam int unsigned AVG_LO = 8;
  localparam int unsigned NOTCH_BIT = 7;
  localparam int unsigned DEC_HI = 6;
  localparam int unsigned DEC_LO = 0;
  localparam int unsigned NORMAL_FILTER_HZ = 512_000;
  localparam int unsigned LOWPWR_FILTER_HZ = 131_000;
  localparam int unsigned DEC_BASE = 64;
  localparam int unsigned AVG_OFFSET = 3;
  localparam int unsigned CHOP_EXTRA = 3;
  localparam logic [6:0] DEC_FORCE60 = 7'h7e;
  localparam logic [6:0] DEC_FORCE50 = 7'h7f;
  localparam int unsigned RATE60_HZ = 60;
  localparam int unsigned RATE50_HZ = 50;
  localparam int unsigned MIN_RATE_NORMAL_HZ = 4;
  localparam int unsigned MIN_RATE_LOWPWR_HZ = 1;
  localparam int unsigned DIV60_NORMAL = NORMAL_FILTER_HZ / RATE60_HZ;
  localparam int unsigned DIV50_NORMAL = NORMAL_FILTER_HZ / RATE50_HZ;
  localparam int unsigned DIV60_LOWPWR = LOWPWR_FILTER_HZ / RATE60_HZ;
  localparam int unsigned DIV50_LOWPWR = LOWPWR_FILTER_HZ / RATE50_HZ;
  localparam int unsigned DIV_MAX_NORMAL =
    NORMAL_FILTER_HZ / MIN_RATE_NORMAL_HZ;
  localparam int unsigned DIV_MAX_LOWPWR =
    LOWPWR_FILTER_HZ / MIN_RATE_LOWPWR_HZ;
  localparam logic [2:0] SETTLE_PLAIN = 3'h3;
  localparam logic [2:0] SETTLE_RUNAVG = 3'h4;
  localparam logic [2:0] SETTLE_AVG = 3'h1;
  localparam logic [2:0] SETTLE_AVG_RUNAVG = 3'h2;
  localparam logic [2:0] SETTLE_CHOP = 3'h2;
  localparam int unsigned FIRST_EXTRA_NS = 60_000;
  localparam int unsigned FIRST_EXTRA_CYCLES =
    (FIRST_EXTRA_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SETTLE = 2'b11,
    ST_RUN = 2'b10
  } sdf_state_e;
endpackage

// ---- logic/sdf_rate_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sdf_rate_if;
  logic [sdf_pkg::DIV_W-1:0] divisor;
  logic lowPower;
  logic restart;
  logic filterTick;
  logic periodTick;
  modport rate (
    input divisor,
    input lowPower,
    input restart,
    output filterTick,
    output periodTick
  );
  modport ctrl (
    output divisor,
    output lowPower,
    output restart,
    input filterTick,
    input periodTick
  );
endinterface
`default_nettype wire

// ---- logic/sdf_rate_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdf_rate_gen (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Link to the control block.
  sdf_rate_if.rate rif
);
  logic [sdf_pkg::ACC_W-1:0] acc_q, acc_d;
  logic [sdf_pkg::DIV_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic period_q, period_d;
  logic [sdf_pkg::ACC_W-1:0] inc;
  logic [sdf_pkg::ACC_W-1:0] sum;

  // Fractional divider gives the filter clock enable, then periods.
  always_comb begin
    inc = rif.lowPower ? sdf_pkg::ACC_W'(sdf_pkg::LOWPWR_FILTER_HZ)
                       : sdf_pkg::ACC_W'(sdf_pkg::NORMAL_FILTER_HZ);
    sum = acc_q + inc;
    acc_d = sum;
    tick_d = 1'b0;
    if (sum >= sdf_pkg::ACC_W'(sdf_pkg::CLK_HZ)) begin
      acc_d = sum - sdf_pkg::ACC_W'(sdf_pkg::CLK_HZ);
      tick_d = 1'b1;
    end
    cnt_d = cnt_q;
    period_d = 1'b0;
    if (rif.restart) begin
      cnt_d = '0;
    end else if (tick_q) begin
      if (cnt_q >= rif.divisor - 21'h000001) begin
        cnt_d = '0;
        period_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 21'h000001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
      cnt_q <= '0;
      tick_q <= 1'b0;
      period_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      period_q <= period_d;
    end
  end

  assign rif.filterTick = tick_q;
  assign rif.periodTick = period_q;
endmodule
`default_nettype wire

// ---- logic/sdf_filter_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdf_filter_ctrl (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // Mode and channel enables.
  input wire logic lowPower,
  input wire logic curAdcOn,
  input wire logic vtAdcOn,
  // Filter configuration.
  output logic chopEnable,
  output logic runAvgActive,
  output logic secondNotch,
  output logic [5:0] averagingCount,
  output logic [6:0] decimationSetting,
  output logic filterClkEn,
  // Channel resets and results.
  output logic curAdcReset,
  output logic vtAdcReset,
  output logic curResultValid,
  output logic vtResultValid,
  output logic settled
);
  sdf_rate_if rif ();

  sdf_rate_gen u_rate (
    .mclk(mclk),
    .resetn(resetn),
    .rif(rif)
  );

  // Register file.
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] ext_q, ext_d;
  logic [15:0] rdata_q, rdata_d;
  logic modified;
  logic wrCtrl;

  // Status and derived configuration.
  logic [sdf_pkg::DIV_W-1:0] div_q, div_d;
  logic [2:0] need_q, need_d;
  logic runAvg_q, runAvg_d;
  logic curRst_q, curRst_d;
  logic vtRst_q, vtRst_d;

  // Settling sequencer.
  sdf_pkg::sdf_state_e state_q, state_d;
  logic [11:0] wait_q, wait_d;
  logic [2:0] per_q, per_d;
  logic restart_q, restart_d;
  logic curVal_q, curVal_d;
  logic vtVal_q, vtVal_d;
  logic settled_q, settled_d;
  logic lpPrev_q, lpPrev_d;
  logic onPrev_q, onPrev_d;
  logic anyOn;
  logic restartReq;

  // Divisor arithmetic.
  logic chop;
  logic runAvgBit;
  logic [5:0] avg;
  logic [6:0] dec;
  logic [sdf_pkg::DIV_W-1:0] base;
  logic [sdf_pkg::DIV_W-1:0] mult;
  logic [sdf_pkg::DIV_W-1:0] prod;
  logic [sdf_pkg::DIV_W-1:0] divMax;

  // Register access, reads answer one cycle after the strobe.
  always_comb begin
    ctrl_d = ctrl_q;
    ext_d = ext_q;
    rdata_d = 16'h0000;
    wrCtrl = regWrite && (regAddr == sdf_pkg::ADDR_FILTER_CTRL);
    modified = wrCtrl && (regWdata != ctrl_q);
    if (wrCtrl) begin
      ctrl_d = regWdata;
    end
    if (regWrite && (regAddr == sdf_pkg::ADDR_EXT_CFG)) begin
      ext_d = regWdata[7:0];
    end
    if (regRead) begin
      case (regAddr)
        sdf_pkg::ADDR_FILTER_CTRL: begin
          rdata_d = ctrl_q;
        end
        sdf_pkg::ADDR_EXT_CFG: begin
          rdata_d = {8'h00, ext_q};
        end
        sdf_pkg::ADDR_STATUS: begin
          rdata_d = {10'h000, per_q, state_q == sdf_pkg::ST_RUN, settled_q,
                     runAvg_q};
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= sdf_pkg::FILTER_CTRL_RESET;
      ext_q <= sdf_pkg::EXT_CFG_RESET;
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      ext_q <= ext_d;
      rdata_q <= rdata_d;
    end
  end

  // Output period divisor and settling length from the control fields.
  always_comb begin
    chop = ctrl_q[sdf_pkg::CHOP_BIT];
    runAvgBit = ctrl_q[sdf_pkg::RUNAVG_BIT];
    avg = ctrl_q[sdf_pkg::AVG_HI:sdf_pkg::AVG_LO];
    dec = ctrl_q[sdf_pkg::DEC_HI:sdf_pkg::DEC_LO];
    base = (sdf_pkg::DIV_W'(dec) + 21'h000001)
           * sdf_pkg::DIV_W'(sdf_pkg::DEC_BASE);
    mult = sdf_pkg::DIV_W'(avg) + sdf_pkg::DIV_W'(sdf_pkg::AVG_OFFSET);
    prod = sdf_pkg::DIV_W'(base * mult);
    if (chop) begin
      div_d = prod + sdf_pkg::DIV_W'(sdf_pkg::CHOP_EXTRA);
    end else if (avg != 6'h00) begin
      div_d = prod;
    end else begin
      div_d = base;
    end
    if (dec == sdf_pkg::DEC_FORCE60) begin
      div_d = lowPower ? sdf_pkg::DIV_W'(sdf_pkg::DIV60_LOWPWR)
                       : sdf_pkg::DIV_W'(sdf_pkg::DIV60_NORMAL);
    end else if (dec == sdf_pkg::DEC_FORCE50) begin
      div_d = lowPower ? sdf_pkg::DIV_W'(sdf_pkg::DIV50_LOWPWR)
                       : sdf_pkg::DIV_W'(sdf_pkg::DIV50_NORMAL);
    end
    divMax = lowPower ? sdf_pkg::DIV_W'(sdf_pkg::DIV_MAX_LOWPWR)
                      : sdf_pkg::DIV_W'(sdf_pkg::DIV_MAX_NORMAL);
    if (div_d > divMax) begin
      div_d = divMax;
    end
    runAvg_d = runAvgBit | chop;
    if (chop) begin
      need_d = sdf_pkg::SETTLE_CHOP;
    end else if (avg != 6'h00) begin
      need_d = runAvgBit ? sdf_pkg::SETTLE_AVG_RUNAVG
                         : sdf_pkg::SETTLE_AVG;
    end else begin
      need_d = runAvgBit ? sdf_pkg::SETTLE_RUNAVG
                         : sdf_pkg::SETTLE_PLAIN;
    end
    curRst_d = modified;
    vtRst_d = modified;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_q <= sdf_pkg::DIV_W'(sdf_pkg::DEC_BASE);
      need_q <= sdf_pkg::SETTLE_PLAIN;
      runAvg_q <= 1'b0;
      curRst_q <= 1'b0;
      vtRst_q <= 1'b0;
    end else begin
      div_q <= div_d;
      need_q <= need_d;
      runAvg_q <= runAvg_d;
      curRst_q <= curRst_d;
      vtRst_q <= vtRst_d;
    end
  end

  // Settling sequencer: 60 us lead-in, settle periods, then results.
  always_comb begin
    anyOn = curAdcOn | vtAdcOn;
    restartReq = modified || (lowPower != lpPrev_q)
                 || (anyOn && !onPrev_q);
    state_d = state_q;
    wait_d = wait_q;
    per_d = per_q;
    restart_d = 1'b0;
    curVal_d = 1'b0;
    vtVal_d = 1'b0;
    settled_d = settled_q;
    lpPrev_d = lowPower;
    onPrev_d = anyOn;
    if (!anyOn) begin
      state_d = sdf_pkg::ST_IDLE;
      settled_d = 1'b0;
    end else if (restartReq) begin
      state_d = sdf_pkg::ST_WAIT;
      wait_d = 12'h000;
      per_d = 3'h0;
      settled_d = 1'b0;
    end else begin
      case (state_q)
        sdf_pkg::ST_IDLE: begin
          state_d = sdf_pkg::ST_IDLE;
        end
        sdf_pkg::ST_WAIT: begin
          if (wait_q >= 12'(sdf_pkg::FIRST_EXTRA_CYCLES - 1)) begin
            state_d = sdf_pkg::ST_SETTLE;
            restart_d = 1'b1;
            per_d = 3'h0;
          end else begin
            wait_d = wait_q + 12'h001;
          end
        end
        sdf_pkg::ST_SETTLE: begin
          // A period tick from the count before the restart is ignored.
          if (rif.periodTick && !restart_q) begin
            if (per_q + 3'h1 >= need_q) begin
              state_d = sdf_pkg::ST_RUN;
              settled_d = 1'b1;
              curVal_d = curAdcOn;
              vtVal_d = vtAdcOn;
            end else begin
              per_d = per_q + 3'h1;
            end
          end
        end
        sdf_pkg::ST_RUN: begin
          if (rif.periodTick) begin
            curVal_d = curAdcOn;
            vtVal_d = vtAdcOn;
          end
        end
        default: begin
          state_d = sdf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= sdf_pkg::ST_IDLE;
      wait_q <= 12'h000;
      per_q <= 3'h0;
      restart_q <= 1'b0;
      curVal_q <= 1'b0;
      vtVal_q <= 1'b0;
      settled_q <= 1'b0;
      lpPrev_q <= 1'b0;
      onPrev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      per_q <= per_d;
      restart_q <= restart_d;
      curVal_q <= curVal_d;
      vtVal_q <= vtVal_d;
      settled_q <= settled_d;
      lpPrev_q <= lpPrev_d;
      onPrev_q <= onPrev_d;
    end
  end

  assign rif.divisor = div_q;
  assign rif.lowPower = lowPower;
  assign rif.restart = restart_q;

  assign regRdata = rdata_q;
  assign chopEnable = ctrl_q[sdf_pkg::CHOP_BIT];
  assign runAvgActive = runAvg_q;
  assign secondNotch = ctrl_q[sdf_pkg::NOTCH_BIT];
  assign averagingCount = ctrl_q[sdf_pkg::AVG_HI:sdf_pkg::AVG_LO];
  assign decimationSetting = ctrl_q[sdf_pkg::DEC_HI:sdf_pkg::DEC_LO];
  assign filterClkEn = rif.filterTick;
  assign curAdcReset = curRst_q;
  assign vtAdcReset = vtRst_q;
  assign curResultValid = curVal_q;
  assign vtResultValid = vtVal_q;
  assign settled = settled_q;
endmodule
`default_nettype wire

// ---- sim/sdf_filter_ctrl_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdf_filter_ctrl_chk (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  // Channels and outputs.
  input wire logic vtAdcOn,
  input wire logic chopEnable,
  input wire logic runAvgActive,
  input wire logic secondNotch,
  input wire logic [5:0] averagingCount,
  input wire logic [6:0] decimationSetting,
  input wire logic curAdcReset,
  input wire logic vtAdcReset,
  input wire logic curResultValid,
  input wire logic vtResultValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic ctrlWr;
  assign ctrlWr = regWrite && regAddr == sdf_pkg::ADDR_FILTER_CTRL;
  a_reset_on_change: assert property (
    ctrlWr && (regWdata[15] != chopEnable
    || regWdata[13:8] != averagingCount || regWdata[7] != secondNotch
    || regWdata[6:0] != decimationSetting)
    |=> curAdcReset && vtAdcReset) else $error("no reset");
  a_reset_cause: assert property (
    curAdcReset || vtAdcReset |-> $past(ctrlWr)) else $error("stray reset");
  a_chop_bit: assert property (
    ctrlWr |=> chopEnable == $past(regWdata[15])) else $error("chop bit");
  a_runavg_forced: assert property (
    chopEnable && $past(chopEnable) |-> runAvgActive) else $error("runavg");
  a_fields_load: assert property (
    ctrlWr |=> averagingCount == $past(regWdata[13:8])
    && decimationSetting == $past(regWdata[6:0])
    && secondNotch == $past(regWdata[7])) else $error("fields");
  a_read_back: assert property (
    regRead && regAddr == sdf_pkg::ADDR_FILTER_CTRL
    |=> regRdata[6:0] == $past(decimationSetting)
    && regRdata[15] == $past(chopEnable)) else $error("readback");
  a_valid_pulse: assert property (
    curResultValid |=> !curResultValid) else $error("valid width");
  a_valid_needs_on: assert property (
    vtResultValid |-> $past(vtAdcOn)) else $error("valid off");
  c_chg: cover property (ctrlWr ##1 curAdcReset);
  c_chop: cover property (chopEnable && curResultValid);
  c_vt: cover property (vtResultValid);
endmodule
bind sdf_filter_ctrl sdf_filter_ctrl_chk chk_u (.*);
`default_nettype wire

// ---- sim/sdf_filter_ctrl_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module sdf_filter_ctrl_bench;
  logic mclk, resetn, regWrite, regRead, lowPower, curAdcOn, vtAdcOn;
  logic [31:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic chopEnable, runAvgActive, secondNotch, filterClkEn, settled;
  logic [5:0] averagingCount;
  logic [6:0] decimationSetting;
  logic curAdcReset, vtAdcReset, curResultValid, vtResultValid;
  int n_errors = 0;
  int total_checks = 0;
  int vtPulses = 0;
  int tickCount = 0;
  sdf_filter_ctrl dut_u (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .lowPower(lowPower), .curAdcOn(curAdcOn),
    .vtAdcOn(vtAdcOn), .chopEnable(chopEnable), .runAvgActive(runAvgActive),
    .secondNotch(secondNotch), .averagingCount(averagingCount),
    .decimationSetting(decimationSetting), .filterClkEn(filterClkEn),
    .curAdcReset(curAdcReset), .vtAdcReset(vtAdcReset),
    .curResultValid(curResultValid), .vtResultValid(vtResultValid),
    .settled(settled));
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(negedge mclk) if (vtResultValid === 1'b1) vtPulses++;
  always @(negedge mclk) if (filterClkEn === 1'b1) tickCount++;
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic wait_valid(input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (curResultValid !== 1'b1 && n < lim);
  endtask
  task automatic t_regs;
    logic [15:0] d;
    rd(sdf_pkg::ADDR_FILTER_CTRL, d);
    `CHK(d, 16'h0007)
    rd(sdf_pkg::ADDR_EXT_CFG, d);
    `CHK(d, 16'h0000)
    wr(sdf_pkg::ADDR_EXT_CFG, 16'hffa5);
    rd(sdf_pkg::ADDR_EXT_CFG, d);
    `CHK(d, 16'h00a5)
    rd(32'hffff0600, d);
    `CHK(d, 16'h0000)
    wr(sdf_pkg::ADDR_FILTER_CTRL, 16'h0007);
    `CHK({curAdcReset, vtAdcReset}, 2'b00)
    wr(sdf_pkg::ADDR_FILTER_CTRL, 16'h3f80);
    `CHK({curAdcReset, vtAdcReset}, 2'b11)
    `CHK({secondNotch, averagingCount}, 7'h7f)
    rd(sdf_pkg::ADDR_FILTER_CTRL, d);
    `CHK(d, 16'h3f80)
    $display("test regs done");
  endtask
  task automatic t_plain;
    int n, per;
    per = 64 * (sdf_pkg::CLK_HZ / 1000) / (sdf_pkg::NORMAL_FILTER_HZ / 1000);
    wr(sdf_pkg::ADDR_FILTER_CTRL, 16'h0000);
    `CHK(runAvgActive, 1'b0)
    wait_valid(40000, n);
    `CHK(n > 3000 + 3 * per - 110 && n < 3000 + 3 * per + 110, 1'b1)
    `CHK(settled, 1'b1)
    wait_valid(40000, n);
    `CHK(n >= per - 2 && n <= per + 2, 1'b1)
    `CHK(vtPulses, 0)
    $display("test plain done");
  endtask
  task automatic t_chop;
    int n, per;
    per = 195 * 9765625 / 100000;
    vtAdcOn <= 1'b1;
    wr(sdf_pkg::ADDR_FILTER_CTRL, 16'h8000);
    `CHK({curAdcReset, vtAdcReset, chopEnable}, 3'b111)
    @(posedge mclk);
    #1 `CHK(runAvgActive, 1'b1)
    wait_valid(60000, n);
    `CHK(n > 3000 + 2 * per - 110 && n < 3000 + 2 * per + 110, 1'b1)
    wait_valid(30000, n);
    `CHK(n >= per - 2 && n <= per + 2, 1'b1)
    `CHK(vtPulses > 0, 1'b1)
    $display("test chop done");
  endtask
  task automatic t_lowpwr;
    int t0;
    t0 = tickCount;
    repeat (2000) @(posedge mclk);
    #1 `CHK(tickCount - t0 >= 20 && tickCount - t0 <= 21, 1'b1)
    lowPower <= 1'b1;
    t0 = tickCount;
    repeat (2000) @(posedge mclk);
    #1 `CHK(tickCount - t0 >= 5 && tickCount - t0 <= 7, 1'b1)
    `CHK(settled, 1'b0)
    $display("test low power done");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    resetn = 0;
    regWrite = 0;
    regRead = 0;
    regAddr = 0;
    regWdata = 0;
    lowPower = 0;
    curAdcOn = 1;
    vtAdcOn = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_plain();
    t_chop();
    t_lowpwr();
    finish_test();
  end
  initial begin
    repeat (97000) @(posedge mclk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
